/* File: verilog/cfl_pkg.sv */
// Purpose: Shared constants and carriers of the capacity flag logic
// Assumes: Readings arrive already scaled to threshold units
// Notes: Fractions use an LSB of 2^-14, age scale an LSB of 2^-7
package cfl_pkg;

    // ************************************************
    // Register map and status fields
    // ************************************************
    localparam logic [7:0] CFL_STATUS_ADDR = 8'h01;
    localparam int CFL_BIT_CHG_DONE = 7;
    localparam int CFL_BIT_ACT_LOW = 6;
    localparam int CFL_BIT_STBY_LOW = 5;
    localparam int CFL_BIT_LEARN = 4;
    localparam int CFL_BIT_RSVD_HI = 3;
    localparam int CFL_BIT_UNDERVOLT = 2;
    localparam int CFL_BIT_POWER_UP = 1;
    localparam int CFL_BIT_RSVD_LO = 0;
    localparam logic [7:0] CFL_STATUS_RESET = 8'h02;

    // ************************************************
    // Scales, limits and timing
    // ************************************************
    localparam logic [7:0] CFL_AGE_RESET = 8'h80;
    localparam logic [20:0] CFL_AGE_WEAR_MULT = 21'h000020;
    localparam logic [14:0] CFL_FRAC_FULL = 15'h4000;
    localparam logic [7:0] CFL_PCT_MAX = 8'h64;
    localparam logic [7:0] CFL_PCT_CHG_CLR = 8'h5a;
    localparam logic [7:0] CFL_PCT_ACT_CLR = 8'h05;
    localparam logic [7:0] CFL_PCT_STBY_SET = 8'h0a;
    localparam logic [7:0] CFL_PCT_STBY_CLR = 8'h0f;
    localparam int CFL_SHUNT_SHIFT = 4;
    localparam int CFL_CLOCK_KHZ = 200000;
    localparam int CFL_PROC_INTERVAL_MS = 3500;
    localparam int CFL_PROC_CYCLES = CFL_PROC_INTERVAL_MS * CFL_CLOCK_KHZ;

    // ************************************************
    // Carriers
    // ************************************************
    typedef struct packed {
        logic [15:0] voltage;
        logic signed [15:0] current;
        logic signed [15:0] avgCurrent;
        logic signed [15:0] ccDelta;
        logic voltStb;
        logic curStb;
        logic avgStb;
        logic accStb;
    } cfl_meas_s;

    typedef struct packed {
        logic [15:0] chargeVoltageThreshold;
        logic [15:0] taperCurrentThreshold;
        logic [15:0] emptyVoltageThreshold;
        logic [15:0] dischargeThreshold;
        logic [15:0] sleepVoltageThreshold;
        logic [15:0] wearRating;
        logic [7:0] shuntConductance;
        logic [15:0] nominalCapacityMvh;
    } cfl_param_s;

    typedef struct packed {
        logic [14:0] fullModel;
        logic [12:0] activeModel;
        logic [12:0] standbyModel;
    } cfl_model_s;

endpackage

/* File: verilog/cfl_capacity_flag_logic.sv */
// Purpose: Aging, learn cycles, count housekeeping, results and flags
// Assumes: Measurement and model inputs come from logic on clock
// Notes: Status at its address over the host register port
//
// Contract
// - Age scale drops per 32 wear ratings discharged
// - Active empty point sets the learn flag
// - Full during learn: clear learn, set done, relearn
// - Charge done loads age-scaled full capacity
// - Age scale updated before count correction
// - Active low alone: lower count to floor
// - Learn at empty: load count with floor
// - Full needs high voltage, two small positive averages
// - Empty point needs low voltage, two big discharges
// - Results recomputed every processing interval
// - Full fraction 15 bits, clamped to 100%
// - Empty fractions are 13-bit values
// - Absolute remaining capacities in 16 bits
// - Relative remaining capacities in 8-bit percent
// - Charge done bit 7, clears below 90%
// - Active low bit 6, clears above 5%
// - Standby low bit 5, hysteresis 10% to 15%
// - Learn bit 4 cleared by listed events
// - Undervolt and power-up cleared only by host
// - Status at 01h, reserved bits zero
// - Age scale 8 bits, 80h means unaged
`timescale 1ns/1ps
`default_nettype none

module cfl_capacity_flag_logic import cfl_pkg::*; #(
    parameter int PROC_CYCLES = CFL_PROC_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire cfl_meas_s meas,
    input wire cfl_param_s param,
    input wire cfl_model_s model,
    input wire logic [7:0] hostAddr,
    input wire logic hostWr,
    input wire logic [7:0] hostWrData,
    input wire logic ccWrite,
    input wire logic ccRecall,
    input wire logic [15:0] ccLoadData,
    input wire logic sleepEnter,
    output logic [7:0] hostRdData,
    output logic [7:0] gaugeStatus,
    output logic [7:0] ageScale,
    output logic [15:0] coulombCount,
    output logic [14:0] fullCapacityAtTemp,
    output logic [12:0] activeFloorAtTemp,
    output logic [12:0] standbyFloorAtTemp,
    output logic [15:0] activeMahLeft,
    output logic [15:0] standbyMahLeft,
    output logic [7:0] activePctLeft,
    output logic [7:0] standbyPctLeft,
    output logic resultStb
);

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic [31:0] tick;
        logic [15:0] cc;
        logic [7:0] age;
        logic [21:0] ageAcc;
        logic [7:0] status;
        logic chgStarted;
        logic [1:0] dischHist;
        logic prevAvgOk;
        logic voltOk;
        logic aboveVae;
        logic fullPend;
        logic loadPend;
        logic resDone;
        logic [14:0] fullT;
        logic [12:0] aeT;
        logic [12:0] seT;
        logic [15:0] active_mah_left;
        logic [15:0] standby_mah_left;
        logic [7:0] active_pct_left;
        logic [7:0] standby_pct_left;
        logic [7:0] rdData;
    } cfl_state_s;

    cfl_state_s s_q;
    cfl_state_s s_d;

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [15:0] fracCnt(input logic [14:0] f,
                                            input logic [15:0] nom);
        logic [30:0] p;
        p = f * nom;
        return p[29:14];
    endfunction

    function automatic logic [7:0] pctOf(input logic [15:0] num,
                                         input logic [15:0] den);
        logic [22:0] n;
        logic [22:0] q;
        n = num * 23'd100;
        q = (den == 16'h0000) ? 23'h0 : n / {7'h0, den};
        return (q > {15'h0, CFL_PCT_MAX}) ? CFL_PCT_MAX : q[7:0];
    endfunction

    function automatic logic [15:0] mahOf(input logic [15:0] num,
                                          input logic [7:0] g);
        logic [23:0] p;
        p = (num * g) >> CFL_SHUNT_SHIFT;
        return (p > 24'h00ffff) ? 16'hffff : p[15:0];
    endfunction

    function automatic logic [15:0] above(input logic [15:0] c,
                                          input logic [15:0] fl);
        return (c > fl) ? c - fl : 16'h0000;
    endfunction

    // ************************************************
    // Combinational terms
    // ************************************************
    logic [14:0] fullClamp;
    logic [15:0] floorA;
    logic [15:0] floorS;
    logic [15:0] modelFull;
    logic [15:0] fullCap;
    logic [38:0] fullProd;
    logic [15:0] learnedAge;
    logic [23:0] learnedNum;
    logic [23:0] learnedQ;
    logic [15:0] learnedDen;
    logic signed [16:0] curX;
    logic signed [16:0] avgX;
    logic bigDisch;
    logic avgOk;
    logic voltBelow;
    logic aeEvent;
    logic fullEvent;
    logic tickWrap;
    logic statusWr;
    logic signed [17:0] ccSum;
    logic [21:0] ageThr;
    logic [21:0] ageSum;

    always_comb begin
        fullClamp = (model.fullModel > CFL_FRAC_FULL) ? CFL_FRAC_FULL
                                                      : model.fullModel;
        floorA = fracCnt({2'b00, s_q.aeT}, param.nominalCapacityMvh);
        floorS = fracCnt({2'b00, s_q.seT}, param.nominalCapacityMvh);
        modelFull = fracCnt(s_q.fullT, param.nominalCapacityMvh);
        fullProd = s_q.age * s_q.fullT * param.nominalCapacityMvh;
        fullCap = (fullProd[38:21] > 18'h0ffff) ? 16'hffff
                                                : fullProd[36:21];
        learnedDen = above(modelFull, floorA);
        learnedNum = {1'b0, above(s_q.cc, floorA), 7'h00};
        learnedQ = (learnedDen == 16'h0000) ? {16'h0, s_q.age}
                                            : learnedNum / {8'h0, learnedDen};
        learnedAge = (learnedQ > 24'h0000ff) ? 16'h00ff : learnedQ[15:0];
        curX = 17'(meas.current);
        avgX = 17'(meas.avgCurrent);
        bigDisch = curX < -$signed({1'b0, param.dischargeThreshold});
        avgOk = (avgX > 17'sd0) &&
                (avgX < $signed({1'b0, param.taperCurrentThreshold}));
        voltBelow = meas.voltage < param.emptyVoltageThreshold;
        aeEvent = meas.voltStb && voltBelow && s_q.aboveVae &&
                  (s_q.dischHist == 2'b11);
        fullEvent = meas.avgStb && avgOk && s_q.prevAvgOk && s_q.voltOk &&
                    (meas.voltage > param.chargeVoltageThreshold);
        tickWrap = s_q.tick == 32'(PROC_CYCLES - 1);
        statusWr = hostWr && (hostAddr == CFL_STATUS_ADDR);
        ccSum = $signed({2'b00, s_q.cc}) + 18'(meas.ccDelta);
        ageThr = {1'b0, param.wearRating * CFL_AGE_WEAR_MULT};
        ageSum = s_q.ageAcc + {6'h00, -meas.ccDelta};
    end

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        s_d = s_q;
        s_d.resDone = 1'b0;
        s_d.fullPend = 1'b0;
        s_d.loadPend = 1'b0;
        s_d.tick = tickWrap ? 32'h0 : s_q.tick + 32'h1;

        // Coulomb count and aging
        if (meas.accStb) begin
            if (ccSum < 18'sd0) begin
                s_d.cc = 16'h0000;
            end else if (ccSum > 18'sh0ffff) begin
                s_d.cc = 16'hffff;
            end else begin
                s_d.cc = ccSum[15:0];
            end
            if (meas.ccDelta < 16'sd0 && s_q.cc != 16'h0000) begin
                if (ageSum >= ageThr && ageThr != 22'h0) begin
                    s_d.ageAcc = 22'h0;
                    if (s_q.age > 8'h01) begin
                        s_d.age = s_q.age - 8'h01;
                    end
                end else begin
                    s_d.ageAcc = ageSum;
                end
            end
        end

        // Empty detect and its count adjustment
        if (meas.curStb) begin
            s_d.dischHist = {s_q.dischHist[0], bigDisch};
            if (curX > 17'sd0 && s_q.status[CFL_BIT_LEARN]) begin
                s_d.chgStarted = 1'b1;
            end
        end
        if (meas.voltStb) begin
            s_d.aboveVae = !voltBelow;
            if (voltBelow) begin
                s_d.status[CFL_BIT_ACT_LOW] = 1'b1;
                if (aeEvent || s_q.status[CFL_BIT_LEARN]) begin
                    s_d.cc = floorA;
                end else if (s_q.cc > floorA) begin
                    s_d.cc = floorA;
                end
            end
            if (meas.voltage <= param.chargeVoltageThreshold) begin
                s_d.voltOk = 1'b0;
            end
            if (meas.voltage < param.sleepVoltageThreshold) begin
                s_d.status[CFL_BIT_UNDERVOLT] = 1'b1;
            end
        end

        // Full detect window
        if (meas.avgStb) begin
            s_d.prevAvgOk = avgOk;
            s_d.voltOk = meas.voltage > param.chargeVoltageThreshold;
        end

        // Host and internal count reloads
        if (ccWrite || ccRecall) begin
            s_d.cc = ccLoadData;
        end

        // Learn sequence: age scale first, count afterwards
        if (s_q.fullPend) begin
            s_d.age = learnedAge[7:0] == 8'h00 ? 8'h01
                                                : learnedAge[7:0];
            s_d.loadPend = 1'b1;
        end
        if (s_q.loadPend) begin
            s_d.cc = fullCap;
        end

        // Periodic results
        if (tickWrap) begin
            s_d.fullT = fullClamp;
            s_d.aeT = model.activeModel;
            s_d.seT = model.standbyModel;
            s_d.active_mah_left = mahOf(above(s_q.cc, floorA),
                             param.shuntConductance);
            s_d.standby_mah_left = mahOf(above(s_q.cc, floorS),
                             param.shuntConductance);
            s_d.active_pct_left = pctOf(above(s_q.cc, floorA),
                             above(fullCap, floorA));
            s_d.standby_pct_left = pctOf(above(s_q.cc, floorS),
                             above(fullCap, floorS));
            s_d.resDone = 1'b1;
        end

        // Flag clears and standby low set from results
        if (s_q.resDone) begin
            if (s_q.active_pct_left < CFL_PCT_CHG_CLR) begin
                s_d.status[CFL_BIT_CHG_DONE] = 1'b0;
            end
            if (s_q.active_pct_left > CFL_PCT_ACT_CLR && !(meas.voltStb && voltBelow)) begin
                s_d.status[CFL_BIT_ACT_LOW] = 1'b0;
            end
            if (s_q.standby_pct_left < CFL_PCT_STBY_SET) begin
                s_d.status[CFL_BIT_STBY_LOW] = 1'b1;
            end else if (s_q.standby_pct_left > CFL_PCT_STBY_CLR) begin
                s_d.status[CFL_BIT_STBY_LOW] = 1'b0;
            end
        end

        // Host clears only the host-clearable bits
        if (statusWr) begin
            s_d.status[CFL_BIT_UNDERVOLT] = s_q.status[CFL_BIT_UNDERVOLT] &
                hostWrData[CFL_BIT_UNDERVOLT];
            s_d.status[CFL_BIT_POWER_UP] = s_q.status[CFL_BIT_POWER_UP] &
                hostWrData[CFL_BIT_POWER_UP];
            if (meas.voltStb &&
                meas.voltage < param.sleepVoltageThreshold) begin
                s_d.status[CFL_BIT_UNDERVOLT] = 1'b1;
            end
        end

        // Learn flag clears, then sets which win
        if ((meas.curStb && curX < 17'sd0 && s_q.chgStarted) ||
            (s_d.cc == 16'h0000 && s_q.cc != 16'h0000) || ccWrite ||
            ccRecall || sleepEnter || fullEvent) begin
            s_d.status[CFL_BIT_LEARN] = 1'b0;
            s_d.chgStarted = 1'b0;
        end
        if (fullEvent) begin
            s_d.status[CFL_BIT_CHG_DONE] = 1'b1;
            if (s_q.status[CFL_BIT_LEARN]) begin
                s_d.fullPend = 1'b1;
            end else begin
                s_d.loadPend = 1'b1;
            end
        end
        if (aeEvent) begin
            s_d.status[CFL_BIT_LEARN] = 1'b1;
            s_d.chgStarted = 1'b0;
        end

        s_d.status[CFL_BIT_RSVD_HI] = 1'b0;
        s_d.status[CFL_BIT_RSVD_LO] = 1'b0;
        s_d.rdData = (hostAddr == CFL_STATUS_ADDR) ? s_d.status
                                                   : 8'h00;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.age <= CFL_AGE_RESET;
            s_q.status <= CFL_STATUS_RESET;
            s_q.rdData <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign hostRdData = s_q.rdData;
    assign gaugeStatus = s_q.status;
    assign ageScale = s_q.age;
    assign coulombCount = s_q.cc;
    assign fullCapacityAtTemp = s_q.fullT;
    assign activeFloorAtTemp = s_q.aeT;
    assign standbyFloorAtTemp = s_q.seT;
    assign activeMahLeft = s_q.active_mah_left;
    assign standbyMahLeft = s_q.standby_mah_left;
    assign activePctLeft = s_q.active_pct_left;
    assign standbyPctLeft = s_q.standby_pct_left;
    assign resultStb = s_q.resDone;

    // ************************************************
    // Checks
    // ************************************************
    power_up_flag_a: assert property (@(posedge clock)
        $fell(rst) |-> s_q.status[CFL_BIT_POWER_UP])
        else $error("power-up flag not set after reset");

    reserved_bits_a: assert property (@(posedge clock) disable iff (rst)
        s_q.status[CFL_BIT_RSVD_HI] == 1'b0 &&
        s_q.status[CFL_BIT_RSVD_LO] == 1'b0)
        else $error("reserved status bit set");

    learn_set_a: assert property (@(posedge clock) disable iff (rst)
        aeEvent |=> s_q.status[CFL_BIT_LEARN] && s_q.cc == $past(floorA))
        else $error("learn flag or floor load missing");

    full_done_a: assert property (@(posedge clock) disable iff (rst)
        fullEvent |=> s_q.status[CFL_BIT_CHG_DONE] &&
        !s_q.status[CFL_BIT_LEARN] ##[0:1] s_q.loadPend)
        else $error("full detect sequence wrong");

    learn_order_a: assert property (@(posedge clock) disable iff (rst)
        s_q.fullPend |=> s_q.loadPend && !s_q.fullPend)
        else $error("count corrected before age scale");

    full_load_a: assert property (@(posedge clock) disable iff (rst)
        s_q.loadPend && !ccWrite && !ccRecall |=>
        s_q.cc == $past(fullCap))
        else $error("count not loaded with full capacity");

    result_tick_a: assert property (@(posedge clock) disable iff (rst)
        tickWrap |=> resultStb ##1 !resultStb [*8])
        else $error("result strobe timing wrong");

    result_range_a: assert property (@(posedge clock) disable iff (rst)
        s_q.active_pct_left <= CFL_PCT_MAX && s_q.standby_pct_left <= CFL_PCT_MAX &&
        s_q.fullT <= CFL_FRAC_FULL)
        else $error("result above its clamp");

    host_clear_a: assert property (@(posedge clock) disable iff (rst)
        $fell(s_q.status[CFL_BIT_UNDERVOLT]) |->
        $past(statusWr))
        else $error("undervolt flag cleared without host write");

    act_low_set_a: assert property (@(posedge clock) disable iff (rst)
        meas.voltStb && voltBelow |=> s_q.status[CFL_BIT_ACT_LOW])
        else $error("active low flag not set");

endmodule

`default_nettype wire

/* File: test/cfl_host_model.sv */
// Purpose: Host side of the status register port
// Assumes: Parallel stand-in for the serial host bus
// Notes: Requests change at falling clock edges only
`timescale 1ns/1ps
`default_nettype none

module cfl_host_model (
    input wire logic clock,
    input wire logic [7:0] hostRdData,
    output logic [7:0] hostAddr,
    output logic hostWr,
    output logic [7:0] hostWrData
);
    initial begin
        hostAddr = 8'h00;
        hostWr = 1'b0;
        hostWrData = 8'h00;
    end

    // ************************************************
    // Register cycles
    // ************************************************
    // Host write, the only path clearing undervolt and power-up
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        hostAddr = a;
        hostWr = 1'b1;
        hostWrData = d;
        @(negedge clock);
        hostWr = 1'b0;
        hostWrData = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        hostAddr = a;
        repeat (2) @(negedge clock);
        d = hostRdData;
    endtask
endmodule

`default_nettype wire

/* File: test/cfl_capacity_flag_logic_tb.sv */
// Purpose: Self-checking bench of the capacity flag logic
// Assumes: Short processing interval of 64 cycles
// Notes: Result expectations pass through a queue to a watcher
`timescale 1ns/1ps
`default_nettype none

module cfl_capacity_flag_logic_tb import cfl_pkg::*;;
    typedef struct packed {
        logic [15:0] pct;
        logic [15:0] mah;
        logic [15:0] full;
        logic [15:0] sfloor;
        logic [15:0] spct;
        logic [15:0] smah;
        logic [15:0] afloor;
    } cfl_exp_s;

    logic clock, rst, ccWrite, ccRecall, sleepEnter, hostWr, resultStb;
    cfl_meas_s meas;
    cfl_param_s param;
    cfl_model_s model;
    logic [7:0] hostAddr, hostWrData, hostRdData, gaugeStatus, ageScale;
    logic [15:0] ccLoadData, coulombCount, activeMahLeft, standbyMahLeft;
    logic [14:0] fullCapacityAtTemp;
    logic [12:0] activeFloorAtTemp, standbyFloorAtTemp;
    logic [7:0] activePctLeft, standbyPctLeft, rd;
    logic [15:0] seed = 16'h0026;
    logic [15:0] nom;
    cfl_exp_s expQ[$];
    cfl_exp_s e;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    time lastStb = 0;

    cfl_capacity_flag_logic #(.PROC_CYCLES(64)) cfl_capacity_flag_logic_inst (
        .clock(clock), .rst(rst), .meas(meas), .param(param), .model(model),
        .hostAddr(hostAddr), .hostWr(hostWr), .hostWrData(hostWrData),
        .ccWrite(ccWrite), .ccRecall(ccRecall), .ccLoadData(ccLoadData),
        .sleepEnter(sleepEnter), .hostRdData(hostRdData),
        .gaugeStatus(gaugeStatus), .ageScale(ageScale),
        .coulombCount(coulombCount), .fullCapacityAtTemp(fullCapacityAtTemp),
        .activeFloorAtTemp(activeFloorAtTemp),
        .standbyFloorAtTemp(standbyFloorAtTemp),
        .activeMahLeft(activeMahLeft), .standbyMahLeft(standbyMahLeft),
        .activePctLeft(activePctLeft), .standbyPctLeft(standbyPctLeft),
        .resultStb(resultStb)
    );

    cfl_host_model cfl_host_model_inst (
        .clock(clock), .hostRdData(hostRdData), .hostAddr(hostAddr),
        .hostWr(hostWr), .hostWrData(hostWrData)
    );

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Kinds: 0 voltage, 1 current, 2 average, 3 count write, 4 sleep,
    // 5 count change
    task automatic strobe(input int k, input logic [15:0] v);
        @(negedge clock);
        case (k)
            0: begin meas.voltage = v; meas.voltStb = 1'b1; end
            1: begin meas.current = v; meas.curStb = 1'b1; end
            2: begin meas.avgCurrent = v; meas.avgStb = 1'b1; end
            3: begin ccLoadData = v; ccWrite = 1'b1; end
            5: begin meas.ccDelta = v; meas.accStb = 1'b1; end
            default: sleepEnter = 1'b1;
        endcase
        @(negedge clock);
        {meas.voltStb, meas.curStb, meas.avgStb, meas.accStb} = 4'b0000;
        ccWrite = 1'b0;
        sleepEnter = 1'b0;
        repeat (3) @(negedge clock);
    endtask

    task automatic empty_point();
        strobe(1, -16'sd200);
        strobe(1, -16'sd200);
        strobe(0, 16'd300);
        strobe(0, 16'd150);
    endtask

    task automatic full_pair();
        strobe(0, 16'd900);
        strobe(2, 16'd10);
        strobe(0, 16'd900);
        strobe(2, 16'd10);
        repeat (2) @(negedge clock);
    endtask

    task automatic wait_result();
        int i;
        for (i = 0; i < 200 && resultStb !== 1'b1; i++) @(negedge clock);
        repeat (2) @(negedge clock);
    endtask

    // ************************************************
    // Clock, timeout and result watcher
    // ************************************************
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    always @(negedge clock) begin
        if (!rst && resultStb === 1'b1) begin
            if (lastStb != 0) check(16'((($time - lastStb)) / 5), 16'd64);
            lastStb = $time;
            if (expQ.size() > 0) begin
                e = expQ.pop_front();
                check({8'h00, activePctLeft}, e.pct);
                check(activeMahLeft, e.mah);
                check({1'b0, fullCapacityAtTemp}, e.full);
                check({3'b000, standbyFloorAtTemp}, e.sfloor);
                check({8'h00, standbyPctLeft}, e.spct);
                check(standbyMahLeft, e.smah);
                check({3'b000, activeFloorAtTemp}, e.afloor);
            end
        end
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        rst = 1'b1;
        meas = '0;
        param = '0;
        model = '0;
        {ccWrite, ccRecall, sleepEnter} = 3'b000;
        ccLoadData = 16'h0000;
        nom = 16'h0100 + (xs() & 16'h0eff);
        param.chargeVoltageThreshold = 16'd800;
        param.taperCurrentThreshold = 16'd50;
        param.emptyVoltageThreshold = 16'd200;
        param.dischargeThreshold = 16'd100;
        param.sleepVoltageThreshold = 16'd50;
        param.wearRating = 16'h0008;
        param.shuntConductance = 8'h10;
        param.nominalCapacityMvh = nom;
        model.fullModel = 15'h4000;
        model.standbyModel = 13'h0123;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        check(gaugeStatus, 8'h02);
        check(ageScale, 8'h80);
        strobe(0, 16'd40);
        check(gaugeStatus, 8'h46);
        rd = 8'(xs());
        cfl_host_model_inst.write_reg(8'h01, rd | 8'h06);
        cfl_host_model_inst.read_reg(8'h01, rd);
        check(rd, 8'h46);
        cfl_host_model_inst.read_reg(8'h02, rd);
        check(rd, 8'h00);
        cfl_host_model_inst.write_reg(8'h01, 8'h00);
        cfl_host_model_inst.read_reg(8'h01, rd);
        check(rd, 8'h40);
        wait_result();
        for (int k = 3; k <= 4; k++) begin
            empty_point();
            check(gaugeStatus, 8'h70);
            strobe(k, 16'h0000);
            check(gaugeStatus, 8'h60);
        end
        full_pair();
        check(coulombCount, nom);
        check(gaugeStatus, 8'he0);
        model.fullModel = 15'h5000;
        wait_result();
        expQ.push_back('{16'd100, nom, 16'h4000, 16'h0123, 16'd100,
                         nom - 16'((32'(nom) * 32'h123) >> 14), 16'h0000});
        for (int i = 0; i < 200 && expQ.size() > 0; i++) @(negedge clock);
        check(16'(expQ.size()), 16'd0);
        repeat (2) @(negedge clock);
        check(gaugeStatus, 8'h80);
        strobe(5, -16'sd128);
        check(ageScale, 8'h80);
        strobe(5, -16'sd128);
        check(ageScale, 8'h7f);
        strobe(3, 16'h0000);
        check(coulombCount, 16'h0000);
        wait_result();
        wait_result();
        check(gaugeStatus, 8'h20);
        model.fullModel = 15'h4000;
        empty_point();
        check(gaugeStatus, 8'h70);
        strobe(2, -16'sd5);
        strobe(0, 16'd900);
        strobe(2, 16'd10);
        check(gaugeStatus[7], 1'b0);
        strobe(5, nom);
        full_pair();
        check(gaugeStatus & 8'h90, 8'h80);
        check(ageScale, 8'h80);
        check(coulombCount, nom);
        wrap_up();
    end
endmodule

`default_nettype wire
